// ### shared/smc_pkg.sv
// Package of the sensor measurement control block: register indices, field positions,
// channel codes, reset values and the conversion sequencer states.
// Assumes a 32-bit AXI4-Lite register bus where each register index sits at byte address index * 4.

package smc_pkg;

	localparam int IDX_W = 8;

	localparam logic [IDX_W-1:0] IDX_CONVERSION_GO_CTRL = 8'h00;
	localparam logic [IDX_W-1:0] IDX_AMP_LO    = 8'h02;
	localparam logic [IDX_W-1:0] IDX_AMP_HI    = 8'h03;
	localparam logic [IDX_W-1:0] IDX_AUX_LO    = 8'h04;
	localparam logic [IDX_W-1:0] IDX_AUX_HI    = 8'h05;
	localparam logic [IDX_W-1:0] IDX_TMP_LO    = 8'h06;
	localparam logic [IDX_W-1:0] IDX_TMP_HI    = 8'h07;
	localparam logic [IDX_W-1:0] IDX_SW_A      = 8'h0F;
	localparam logic [IDX_W-1:0] IDX_BIAS_LVL  = 8'h10;
	localparam logic [IDX_W-1:0] IDX_SW_C      = 8'h11;
	localparam logic [IDX_W-1:0] IDX_PWR       = 8'h12;
	localparam logic [IDX_W-1:0] IDX_OPTS      = 8'h20;
	localparam logic [IDX_W-1:0] IDX_IRQ_ST    = 8'h21;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK  = 8'h22;

	localparam int MC_MODE_BIT = 0;
	localparam int MC_CHAN_LO  = 1;
	localparam int MC_CHAN_HI  = 2;
	localparam int MC_GO_BIT   = 3;

	localparam logic [1:0] CH_TEMP = 2'h0;
	localparam logic [1:0] CH_AMP  = 2'h1;
	localparam logic [1:0] CH_AUX  = 2'h2;

	localparam int SWA_LADDER_TIA = 5;
	localparam int SWA_LADDER_POT = 4;
	localparam int SWC_SENSOR_TIA = 6;
	localparam int SWC_SENSOR_POT = 5;
	localparam int SWC_PATH_SEL   = 3;
	localparam int SWC_GAIN_EN    = 2;

	localparam int PWR_LADDER = 7;
	localparam int PWR_TIA    = 6;
	localparam int PWR_POT    = 5;
	localparam int PWR_OSC    = 4;

	localparam int BIAS_TIA_HI = 7;
	localparam int BIAS_TIA_LO = 5;
	localparam int BIAS_POT_HI = 4;
	localparam int BIAS_POT_LO = 0;

	localparam int OPT_SHORT    = 0;
	localparam int OPT_DIAG     = 1;
	localparam int OPT_REF_SEL  = 2;
	localparam int OPT_TOPOLOGY = 3;
	localparam int OPT_GAIN_LO  = 4;
	localparam int OPT_GAIN_HI  = 5;

	localparam int IRQ_W        = 4;
	localparam int IRQ_TEMP     = 0;
	localparam int IRQ_AMP      = 1;
	localparam int IRQ_AUX      = 2;
	localparam int IRQ_REFUSED  = 3;

	localparam int TEMP_W = 10;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {SMC_IDLE, SMC_WAIT} smc_state_t;

endpackage : smc_pkg

// ### hdl/smc_top.sv
// Register front end and conversion sequencer of the sensor measurement control block.
// Assumes an AXI4-Lite master on aclk and an external converter that takes a start pulse and
// raises conv_done asynchronously with conv_result held stable while conv_done is high.
`timescale 1ns/1ns
`default_nettype none

module smc_top
	import smc_pkg::*;
#(
	parameter int ADDR_W = 10,
	parameter int RES_W  = 16
) (
	// Clock and reset.
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write channels.
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output var  logic              awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output var  logic              wready,
	output var  logic [1:0]        bresp,
	output var  logic              bvalid,
	input  wire logic              bready,
	// AXI4-Lite read channels.
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output var  logic              arready,
	output var  logic [31:0]       rdata,
	output var  logic [1:0]        rresp,
	output var  logic              rvalid,
	input  wire logic              rready,
	// Converter handshake.
	output var  logic              conv_start,
	output var  logic [1:0]        conv_channel,
	input  wire logic              conv_done,
	input  wire logic [RES_W-1:0]  conv_result,
	// Power, switch and bias controls of the analog blocks.
	output var  logic              power_ladder,
	output var  logic              power_tia,
	output var  logic              power_potentiostat,
	output var  logic              power_oscillator,
	output var  logic              ladder_to_tia_switch,
	output var  logic              ladder_to_potentiostat_switch,
	output var  logic              sensor_to_tia_switch,
	output var  logic              sensor_to_potentiostat_switch,
	output var  logic              ladder_path_select,
	output var  logic              gain_stage_enable,
	output var  logic [2:0]        tia_bias_level,
	output var  logic [4:0]        potentiostat_bias_level,
	output var  logic              cell_short_switch,
	output var  logic              diagnostic_offset_enable,
	output var  logic              ladder_reference_select,
	output var  logic              gain_stage_topology,
	output var  logic [3:0]        gain_stage_gain,
	// Interrupt.
	output var  logic              irq
);

	if (ADDR_W < IDX_W + 2 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie between IDX_W+2 and 32.");
	end
	if (RES_W != 16) begin : g_bad_res
		$error("RES_W must be 16, the result registers are two bytes.");
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Decoding helpers.

	function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
		case (idx)
			IDX_CONVERSION_GO_CTRL, IDX_AMP_LO, IDX_AMP_HI, IDX_AUX_LO, IDX_AUX_HI, IDX_TMP_LO, IDX_TMP_HI,
			IDX_SW_A, IDX_BIAS_LVL, IDX_SW_C, IDX_PWR, IDX_OPTS, IDX_IRQ_ST, IDX_IRQ_MASK: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	function automatic logic [3:0] gain_of(input logic [1:0] code);
		gain_of = 4'h1 << code;
	endfunction : gain_of

	////////////////////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave. Address and data are held separately so either may arrive first.

	logic              aw_hold_ff, w_hold_ff, bvalid_ff, awready_ff, wready_ff, arready_ff, rvalid_ff;
	logic [IDX_W-1:0]  wr_idx_ff;
	logic [7:0]        wbyte_ff;
	logic              wlane_ff;
	logic [1:0]        bresp_ff, rresp_ff;
	logic [31:0]       rdata_ff;
	logic              nxt_aw_hold, nxt_w_hold, nxt_bvalid, nxt_rvalid, wr_do, ar_take;
	logic [IDX_W-1:0]  rd_idx;

	assign wr_do       = aw_hold_ff && w_hold_ff && !bvalid_ff;
	assign nxt_aw_hold = (awvalid && awready_ff) || (aw_hold_ff && !wr_do);
	assign nxt_w_hold  = (wvalid && wready_ff) || (w_hold_ff && !wr_do);
	assign nxt_bvalid  = wr_do || (bvalid_ff && !bready);
	assign ar_take     = arvalid && arready_ff;
	assign nxt_rvalid  = ar_take || (rvalid_ff && !rready);
	assign rd_idx      = araddr[IDX_W+1:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			wr_idx_ff  <= '0;
			wbyte_ff   <= REG_RESET;
			wlane_ff   <= 1'b0;
		end else begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff  <= nxt_w_hold;
			bvalid_ff  <= nxt_bvalid;
			awready_ff <= !nxt_aw_hold && !nxt_bvalid;
			wready_ff  <= !nxt_w_hold && !nxt_bvalid;
			if (awvalid && awready_ff)
				wr_idx_ff <= awaddr[IDX_W+1:2];
			if (wvalid && wready_ff) begin
				wbyte_ff <= wdata[7:0];
				wlane_ff <= wstrb[0];
			end
			if (wr_do)
				bresp_ff <= is_mapped(wr_idx_ff) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// Register file state, declared here so the read mux can see it.
	logic             mode_ff, go_ff, stop_ff;
	logic [1:0]       chan_ff;
	logic [7:0]       sw_a_ff, sw_c_ff, bias_ff, pwr_ff, opts_ff;
	logic [RES_W-1:0] amp_res_ff, aux_res_ff;
	logic [TEMP_W-1:0] tmp_res_ff;
	logic [IRQ_W-1:0] irq_st_ff, irq_mask_ff;
	logic [7:0]       rd_byte;

	always_comb begin
		case (rd_idx)
			IDX_CONVERSION_GO_CTRL: rd_byte = {4'h0, go_ff, chan_ff, mode_ff};
			IDX_AMP_LO:    rd_byte = amp_res_ff[7:0];
			IDX_AMP_HI:    rd_byte = amp_res_ff[15:8];
			IDX_AUX_LO:    rd_byte = aux_res_ff[7:0];
			IDX_AUX_HI:    rd_byte = aux_res_ff[15:8];
			IDX_TMP_LO:    rd_byte = tmp_res_ff[7:0];
			IDX_TMP_HI:    rd_byte = {6'h00, tmp_res_ff[TEMP_W-1:8]};
			IDX_SW_A:      rd_byte = sw_a_ff;
			IDX_BIAS_LVL:  rd_byte = bias_ff;
			IDX_SW_C:      rd_byte = sw_c_ff;
			IDX_PWR:       rd_byte = pwr_ff;
			IDX_OPTS:      rd_byte = opts_ff;
			IDX_IRQ_ST:    rd_byte = {4'h0, irq_st_ff};
			IDX_IRQ_MASK:  rd_byte = {4'h0, irq_mask_ff};
			default:       rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= RESP_OKAY;
		end else begin
			arready_ff <= !nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
			if (ar_take) begin
				rdata_ff <= {24'h00_0000, rd_byte};
				rresp_ff <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Configuration registers. They change only on a software write.

	logic wr_en;
	assign wr_en = wr_do && wlane_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_a_ff     <= REG_RESET;
			sw_c_ff     <= REG_RESET;
			bias_ff     <= REG_RESET;
			pwr_ff      <= REG_RESET;
			opts_ff     <= REG_RESET;
			irq_mask_ff <= '0;
		end else if (wr_en) begin
			case (wr_idx_ff)
				IDX_SW_A:     sw_a_ff     <= wbyte_ff;
				IDX_SW_C:     sw_c_ff     <= wbyte_ff;
				IDX_BIAS_LVL: bias_ff     <= wbyte_ff;
				IDX_PWR:      pwr_ff      <= wbyte_ff;
				IDX_OPTS:     opts_ff     <= wbyte_ff;
				IDX_IRQ_MASK: irq_mask_ff <= wbyte_ff[IRQ_W-1:0];
				default:      ;
			endcase
		end
	end

	logic [3:0] gain_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			gain_ff <= gain_of(2'h0);
		else
			gain_ff <= gain_of(opts_ff[OPT_GAIN_HI:OPT_GAIN_LO]);
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Completion input. Three flip-flops; a change counts once the second and third agree.

	logic done_s1_ff, done_s2_ff, done_s3_ff, done_lvl_ff, done_evt;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_s1_ff  <= 1'b0;
			done_s2_ff  <= 1'b0;
			done_s3_ff  <= 1'b0;
			done_lvl_ff <= 1'b0;
		end else begin
			done_s1_ff <= conv_done;
			done_s2_ff <= done_s1_ff;
			done_s3_ff <= done_s2_ff;
			if (done_s2_ff == done_s3_ff)
				done_lvl_ff <= done_s3_ff;
		end
	end

	assign done_evt = done_s2_ff && done_s3_ff && !done_lvl_ff;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer.

	smc_state_t state_ff;
	logic       ctrl_wr, start_req, stop_req, restart, conv_start_ff;
	logic [1:0] conv_ch_ff;

	assign ctrl_wr   = wr_en && (wr_idx_ff == IDX_CONVERSION_GO_CTRL);
	assign start_req = ctrl_wr && wbyte_ff[MC_GO_BIT];
	assign stop_req  = ctrl_wr && !wbyte_ff[MC_GO_BIT];
	// A start written in the completion cycle wins over the clear, so it is never lost.
	assign restart   = start_req || (mode_ff && !stop_ff && !stop_req);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_ff <= 1'b0;
			chan_ff <= CH_TEMP;
		end else if (ctrl_wr) begin
			mode_ff <= wbyte_ff[MC_MODE_BIT];
			chan_ff <= wbyte_ff[MC_CHAN_HI:MC_CHAN_LO];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff      <= SMC_IDLE;
			go_ff         <= 1'b0;
			stop_ff       <= 1'b0;
			conv_start_ff <= 1'b0;
			conv_ch_ff    <= CH_TEMP;
		end else begin
			conv_start_ff <= 1'b0;
			case (state_ff)
				SMC_IDLE: begin
					if (start_req) begin
						go_ff         <= 1'b1;
						stop_ff       <= 1'b0;
						conv_start_ff <= 1'b1;
						conv_ch_ff    <= wbyte_ff[MC_CHAN_HI:MC_CHAN_LO];
						state_ff      <= SMC_WAIT;
					end
				end
				SMC_WAIT: begin
					if (stop_req)
						stop_ff <= 1'b1;
					if (done_evt) begin
						if (restart) begin
							stop_ff       <= 1'b0;
							conv_start_ff <= 1'b1;
							conv_ch_ff    <= start_req ? wbyte_ff[MC_CHAN_HI:MC_CHAN_LO] : chan_ff;
						end else begin
							go_ff    <= 1'b0;
							state_ff <= SMC_IDLE;
						end
					end
				end
				default: state_ff <= SMC_IDLE;
			endcase
		end
	end

	// Results only move when a conversion of their own channel completes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			amp_res_ff <= '0;
			aux_res_ff <= '0;
			tmp_res_ff <= '0;
		end else if (done_evt && state_ff == SMC_WAIT) begin
			case (conv_ch_ff)
				CH_AMP:  amp_res_ff <= conv_result;
				CH_AUX:  aux_res_ff <= conv_result;
				CH_TEMP: tmp_res_ff <= conv_result[TEMP_W-1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Interrupt status: set by events, cleared by writing one; a set in the clear cycle wins.

	logic [IRQ_W-1:0] irq_evt, irq_clr;
	logic             irq_ff;

	always_comb begin
		irq_evt = '0;
		irq_evt[IRQ_TEMP]    = done_evt && state_ff == SMC_WAIT && conv_ch_ff == CH_TEMP;
		irq_evt[IRQ_AMP]     = done_evt && state_ff == SMC_WAIT && conv_ch_ff == CH_AMP;
		irq_evt[IRQ_AUX]     = done_evt && state_ff == SMC_WAIT && conv_ch_ff == CH_AUX;
		irq_evt[IRQ_REFUSED] = start_req && state_ff == SMC_WAIT && !done_evt;
		irq_clr = (wr_en && wr_idx_ff == IDX_IRQ_ST) ? wbyte_ff[IRQ_W-1:0] : '0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_st_ff <= '0;
			irq_ff    <= 1'b0;
		end else begin
			irq_st_ff <= (irq_st_ff & ~irq_clr) | irq_evt;
			irq_ff    <= |(irq_st_ff & irq_mask_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Output wiring, each straight from a flip-flop.

	assign awready                       = awready_ff;
	assign wready                        = wready_ff;
	assign bvalid                        = bvalid_ff;
	assign bresp                         = bresp_ff;
	assign arready                       = arready_ff;
	assign rvalid                        = rvalid_ff;
	assign rdata                         = rdata_ff;
	assign rresp                         = rresp_ff;
	assign conv_start                    = conv_start_ff;
	assign conv_channel                  = conv_ch_ff;
	assign power_ladder                  = pwr_ff[PWR_LADDER];
	assign power_tia                     = pwr_ff[PWR_TIA];
	assign power_potentiostat            = pwr_ff[PWR_POT];
	assign power_oscillator              = pwr_ff[PWR_OSC];
	assign ladder_to_tia_switch          = sw_a_ff[SWA_LADDER_TIA];
	assign ladder_to_potentiostat_switch = sw_a_ff[SWA_LADDER_POT];
	assign sensor_to_tia_switch          = sw_c_ff[SWC_SENSOR_TIA];
	assign sensor_to_potentiostat_switch = sw_c_ff[SWC_SENSOR_POT];
	assign ladder_path_select            = sw_c_ff[SWC_PATH_SEL];
	assign gain_stage_enable             = sw_c_ff[SWC_GAIN_EN];
	assign tia_bias_level                = bias_ff[BIAS_TIA_HI:BIAS_TIA_LO];
	assign potentiostat_bias_level       = bias_ff[BIAS_POT_HI:BIAS_POT_LO];
	assign cell_short_switch             = opts_ff[OPT_SHORT];
	assign diagnostic_offset_enable      = opts_ff[OPT_DIAG];
	assign ladder_reference_select       = opts_ff[OPT_REF_SEL];
	assign gain_stage_topology           = opts_ff[OPT_TOPOLOGY];
	assign gain_stage_gain               = gain_ff;
	assign irq                           = irq_ff;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_amp_route;
		start_req && state_ff == SMC_IDLE && wbyte_ff[MC_CHAN_HI:MC_CHAN_LO] == CH_AMP
			|=> conv_start && conv_channel == CH_AMP;
	endproperty
	a_amp_route: assert property (p_amp_route) else $error("Amplifier channel not started.");

	property p_aux_result;
		done_evt && state_ff == SMC_WAIT && conv_ch_ff == CH_AUX |=> aux_res_ff == $past(conv_result);
	endproperty
	a_aux_result: assert property (p_aux_result) else $error("Auxiliary result not stored.");

	property p_single_ends;
		done_evt && state_ff == SMC_WAIT && !mode_ff && !start_req |=> !go_ff && state_ff == SMC_IDLE;
	endproperty
	a_single_ends: assert property (p_single_ends) else $error("Single conversion did not end.");

	property p_go_held;
		start_req && state_ff == SMC_IDLE |=> go_ff throughout (!done_evt [*2]);
	endproperty
	a_go_held: assert property (p_go_held) else $error("Go bit dropped while converting.");

	property p_amp_result;
		done_evt && state_ff == SMC_WAIT && conv_ch_ff == CH_AMP |=> amp_res_ff == $past(conv_result);
	endproperty
	a_amp_result: assert property (p_amp_result) else $error("Amplifier result not stored.");

	property p_power_70;
		wr_en && wr_idx_ff == IDX_PWR && wbyte_ff == 8'h70
			|=> power_tia && power_potentiostat && power_oscillator && !power_ladder;
	endproperty
	a_power_70: assert property (p_power_70) else $error("Amplifier power pattern wrong.");

	property p_power_f0;
		wr_en && wr_idx_ff == IDX_PWR && wbyte_ff == 8'hF0
			|=> power_tia && power_potentiostat && power_oscillator && power_ladder;
	endproperty
	a_power_f0: assert property (p_power_f0) else $error("Ladder power pattern wrong.");

	property p_switch_a;
		wr_en && wr_idx_ff == IDX_SW_A |=> ladder_to_tia_switch == $past(wbyte_ff[SWA_LADDER_TIA])
			&& ladder_to_potentiostat_switch == $past(wbyte_ff[SWA_LADDER_POT]);
	endproperty
	a_switch_a: assert property (p_switch_a) else $error("Ladder switches do not follow write.");

	property p_temp_result;
		done_evt && state_ff == SMC_WAIT && conv_ch_ff == CH_TEMP
			|=> tmp_res_ff == $past(conv_result[TEMP_W-1:0]);
	endproperty
	a_temp_result: assert property (p_temp_result) else $error("Temperature result not stored.");

	property p_gain;
		$stable(opts_ff) [*2] |-> gain_stage_gain == gain_of(opts_ff[OPT_GAIN_HI:OPT_GAIN_LO]);
	endproperty
	a_gain: assert property (p_gain) else $error("Gain factor wrong.");

	property p_hold;
		!done_evt |=> $stable(amp_res_ff) && $stable(aux_res_ff) && $stable(tmp_res_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("Result changed without conversion.");

	c_amp_conv: cover property (conv_start && conv_channel == CH_AMP ##[1:50] done_evt);
	c_restart:  cover property (done_evt && state_ff == SMC_WAIT && restart);
	c_irq:      cover property (irq);

endmodule : smc_top

`default_nettype wire

// ### verif/smc_testbench.sv
// Self-checking bench of the sensor measurement control block.
// Assumes the block alone on aclk; the bench is both AXI4-Lite master and converter.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module testbench import smc_pkg::*;;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, conv_done = 0;
	logic [9:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic [15:0] conv_result = 0;
	logic [1:0] bresp, rresp, rr, conv_channel, last_ch;
	logic awready, wready, bvalid, arready, rvalid, conv_start, irq, p_lad, p_tia, p_pot, p_osc;
	logic l2t, l2p, s2t, s2p, path, gen, shrt, diag, rsel, topo;
	logic [2:0] tia_b;
	logic [4:0] pot_b;
	logic [3:0] gain;
	int miscompares = 0, samples_checked = 0, n_starts = 0;

	smc_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .conv_start(conv_start),
		.conv_channel(conv_channel), .conv_done(conv_done), .conv_result(conv_result), .power_ladder(p_lad),
		.power_tia(p_tia), .power_potentiostat(p_pot), .power_oscillator(p_osc), .ladder_to_tia_switch(l2t),
		.ladder_to_potentiostat_switch(l2p), .sensor_to_tia_switch(s2t), .sensor_to_potentiostat_switch(s2p),
		.ladder_path_select(path), .gain_stage_enable(gen), .tia_bias_level(tia_b),
		.potentiostat_bias_level(pot_b), .cell_short_switch(shrt), .diagnostic_offset_enable(diag),
		.ladder_reference_select(rsel), .gain_stage_topology(topo), .gain_stage_gain(gain), .irq(irq));

	always #5 aclk = ~aclk;
	always @(posedge aclk) if (conv_start === 1'b1) begin
		n_starts <= n_starts + 1;
		last_ch <= conv_channel;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Handshakes are judged at the falling edge, where the registered readies already hold their edge value.
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic a, w, b;
		@(posedge aclk);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			a = awvalid & awready;
			w = wvalid & wready;
			b = bvalid & bready;
			rr = bresp;
			@(posedge aclk);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (b) bready <= 1'b0;
		end while (!b);
	endtask : wr

	task automatic rdr(input logic [7:0] idx);
		logic a, b;
		@(posedge aclk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			a = arvalid & arready;
			b = rvalid & rready;
			rd = rdata;
			rr = rresp;
			@(posedge aclk);
			if (a) arvalid <= 1'b0;
			if (b) rready <= 1'b0;
		end while (!b);
	endtask : rdr

	task automatic rchk(input string n, input logic [7:0] idx, input logic [7:0] e);
		rdr(idx);
		`CHK(n, {24'h0, e}, rd)
		`CHK("rresp", RESP_OKAY, rr)
	endtask : rchk

	task automatic conv(input logic [1:0] ch, input logic [15:0] res);
		int k, j;
		k = n_starts;
		wr(IDX_CONVERSION_GO_CTRL, {4'h1, ch, 1'b0});
		rchk("go_busy", IDX_CONVERSION_GO_CTRL, {4'h1, ch, 1'b0});
		`CHK("chan", ch, last_ch)
		@(posedge aclk);
		conv_result <= res;
		conv_done <= 1'b1;
		j = 0;
		do begin
			rdr(IDX_CONVERSION_GO_CTRL);
			j++;
		end while (rd[3] !== 1'b0 && j < 20);
		`CHK("go_done", {28'h0, 1'b0, ch, 1'b0}, rd)
		@(posedge aclk);
		conv_done <= 1'b0;
		repeat (5) @(posedge aclk);
		`CHK("single", k + 1, n_starts)
	endtask : conv

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_config();
		logic [7:0] d;
		`CHK("gain_rst", 4'h1, gain)
		wr(IDX_PWR, 8'h70);
		`CHK("pwr70", 4'h7, {p_lad, p_tia, p_pot, p_osc})
		wr(IDX_PWR, 8'hF0);
		`CHK("pwrF0", 4'hF, {p_lad, p_tia, p_pot, p_osc})
		wr(IDX_SW_A, 8'h20);
		`CHK("swa", 2'h2, {l2t, l2p})
		wr(IDX_SW_C, 8'h48);
		`CHK("swc", 4'hA, {s2t, s2p, path, gen})
		wr(IDX_SW_C, 8'h2C);
		`CHK("swc2", 4'h7, {s2t, s2p, path, gen})
		wr(IDX_BIAS_LVL, 8'hB6);
		`CHK("bias", 8'hB6, {tia_b, pot_b})
		for (int g = 0; g < 4; g++) begin
			d = {2'h0, g[1:0], g[0] ? 4'h5 : 4'hA};
			wr(IDX_OPTS, d);
			@(negedge aclk);
			`CHK("opts", d[3:0], {topo, rsel, diag, shrt})
			`CHK("gain", 4'h1 << g, gain)
		end
	endtask : t_config

	task automatic t_convert();
		conv(CH_TEMP, 16'hFE5A);
		rchk("tmp_lo", IDX_TMP_LO, 8'h5A);
		rchk("tmp_hi", IDX_TMP_HI, 8'h02);
		`CHK("irq_off", 1'b0, irq)
		wr(IDX_IRQ_MASK, 8'h02);
		conv(CH_AMP, 16'hA5C3);
		rchk("amp_lo", IDX_AMP_LO, 8'hC3);
		rchk("amp_hi", IDX_AMP_HI, 8'hA5);
		`CHK("irq_on", 1'b1, irq)
		wr(IDX_IRQ_ST, 8'h02);
		repeat (2) @(posedge aclk);
		`CHK("irq_clr", 1'b0, irq)
		conv(CH_AUX, 16'h3C96);
		rchk("aux_lo", IDX_AUX_LO, 8'h96);
		rchk("aux_hi", IDX_AUX_HI, 8'h3C);
		`CHK("irq_mask", 1'b0, irq)
		rchk("irq_st", IDX_IRQ_ST, 8'h05);
	endtask : t_convert

	task automatic t_refuse();
		wr(8'h30, 8'h55);
		`CHK("wr_unmap", RESP_SLVERR, rr)
		rdr(8'h30);
		`CHK("rd_unmap", {RESP_SLVERR, 32'h0}, {rr, rd})
		wr(IDX_AMP_LO, 8'h00);
		`CHK("wr_ro", RESP_OKAY, rr)
		rchk("amp_keep", IDX_AMP_LO, 8'hC3);
		rchk("swc_keep", IDX_SW_C, 8'h2C);
	endtask : t_refuse

	task automatic pulse_done(input logic [15:0] res);
		@(posedge aclk);
		conv_result <= res;
		conv_done <= 1'b1;
		repeat (8) @(posedge aclk);
		conv_done <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask : pulse_done

	// Continuous mode, a start refused while busy, and a stop that ends the run after the current conversion.
	task automatic t_modes();
		int k;
		k = n_starts;
		wr(IDX_CONVERSION_GO_CTRL, 8'h0B);
		wr(IDX_CONVERSION_GO_CTRL, 8'h0B);
		rchk("refused", IDX_IRQ_ST, 8'h0D);
		`CHK("no_restart", k + 1, n_starts)
		pulse_done(16'h1234);
		`CHK("restart", k + 2, n_starts)
		rchk("go_cont", IDX_CONVERSION_GO_CTRL, 8'h0B);
		wr(IDX_CONVERSION_GO_CTRL, 8'h02);
		pulse_done(16'h5678);
		rchk("go_stop", IDX_CONVERSION_GO_CTRL, 8'h02);
		`CHK("stop", k + 2, n_starts)
		rchk("amp_cont", IDX_AMP_LO, 8'h78);
	endtask : t_modes

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_config();
		t_convert();
		t_refuse();
		t_modes();
		close_out();
	end

	initial begin
		#100000;
		miscompares++;
		close_out();
	end
endmodule : testbench
`default_nettype wire
